/* File: hdl/sfr_regs.vh */
`ifndef SFR_REGS_VH
`define SFR_REGS_VH
// Default instruction codes, overridable by module parameters
`define SFR_OP_FAST_READ 8'h0B
`define SFR_OP_PAGE_WRITE 8'h02
`define SFR_OP_SECTOR_CLEAR 8'hD8
`define SFR_OP_ARRAY_CLEAR 8'hC7
`define SFR_OP_SIGNATURE 8'hAB
`define SFR_OP_WRITE_ENABLE 8'h06
// Arbitrary signature value
`define SFR_SIGNATURE 8'h5A
`define SFR_ERASED 8'hFF
`define SFR_ADDR_BYTES 2'h2
`define SFR_PAGE_W 8
`endif

/* File: hdl/sfr_array.v */
`timescale 1ns/10ps
`include "sfr_regs.vh"
module sfr_array #(
    parameter ADDR_W = 12
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire wr_en_in,
    input wire [ADDR_W-1:0] wr_addr_in,
    input wire [7:0] wr_data_in,
    input wire [ADDR_W-1:0] rd_addr_in,
    output wire [7:0] rd_data_out
);
    localparam DEPTH = 1 << ADDR_W;
    reg [7:0] mem_reg [0:DEPTH-1];
    integer i;

    assign rd_data_out = mem_reg[rd_addr_in];

    // Array comes out of reset erased
    always @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                mem_reg[i] <= `SFR_ERASED;
        end
        else if (wr_en_in)
        begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
    end
endmodule // sfr_array

/* File: hdl/sfr_flash_core.v */
// Overview of operation
// - Fast read: opcode, 24-bit address, dummy byte
// - Read data shifts out on falling edges
// - Read address increments, wraps to zero
// - Chip select high ends read, releases output
// - Fast read refused while cycle busy
// - Top address bit ignored for read, erase
// - Program and erases need write enable latch
// - Page data wraps within same page
// - Over 256 bytes keeps final 256
// - Program clears bits only, addressed bytes only
// - Program runs only on byte boundary
// - Sector erase only after third address byte
// - Bulk erase only right after opcode
// - Valid sequence starts self-timed busy cycle
// - Write enable latch cleared during cycle
// - Protection checks the addressed byte only; the rest of its page or sector can be altered
// - Sector erase sets whole sector to ones
// - Bulk erase only when protection is zero
// - Signature read: opcode, three dummy bytes
// - Signature repeats while select stays low
// - Select high anytime returns to standby
// - Reset leaves standby, latch and busy clear
`timescale 1ns/10ps
`include "sfr_regs.vh"
module sfr_flash_core #(
    parameter ADDR_W = 12,
    parameter SECT_W = 10,
    parameter [7:0] OP_FAST_READ = `SFR_OP_FAST_READ,
    parameter [7:0] OP_PAGE_WRITE = `SFR_OP_PAGE_WRITE,
    parameter [7:0] OP_SECTOR_CLEAR = `SFR_OP_SECTOR_CLEAR,
    parameter [7:0] OP_ARRAY_CLEAR = `SFR_OP_ARRAY_CLEAR,
    parameter [7:0] OP_SIGNATURE = `SFR_OP_SIGNATURE,
    parameter [7:0] OP_WRITE_ENABLE = `SFR_OP_WRITE_ENABLE,
    parameter [7:0] SIGNATURE = `SFR_SIGNATURE
) (
    input wire mclk_in,
    input wire rstn_in,
    input wire sclk_in,
    input wire cs_n_in,
    input wire mosi_in,
    input wire [2:0] block_protect_in,
    output reg miso_out,
    output reg miso_oe_out,
    output reg write_in_progress_out,
    output reg write_enable_latch_out
);
    localparam PAGE = 1 << `SFR_PAGE_W;
    localparam [7:0] ST_IDLE = 8'h01;
    localparam [7:0] ST_CMD = 8'h02;
    localparam [7:0] ST_ADDR = 8'h04;
    localparam [7:0] ST_DUMMY = 8'h08;
    localparam [7:0] ST_READ = 8'h10;
    localparam [7:0] ST_PDATA = 8'h20;
    localparam [7:0] ST_SIG = 8'h40;
    localparam [7:0] ST_HOLD = 8'h80;

    // Protected span is the top 1/64 .. whole array, by block protect code
    function prot_hit;
        input [ADDR_W-1:0] addr;
        input [2:0] bp;
        reg [ADDR_W:0] full;
        reg [ADDR_W:0] lim;
        begin
            full = {1'b1, {ADDR_W{1'b0}}};
            lim = full - (full >> (3'h7 - bp));
            prot_hit = (bp != 3'h0) && ({1'b0, addr} >= lim);
        end
    endfunction

    reg rst_s1_reg, rst_s2_reg;
    reg sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
    reg cs_s1_reg, cs_s2_reg, cs_s3_reg;
    reg mosi_s1_reg, mosi_s2_reg;
    reg [2:0] bp_s1_reg, bp_s2_reg;
    reg [7:0] state_reg;
    reg [7:0] cmd_reg;
    reg [2:0] bit_reg;
    reg [6:0] sh_reg;
    reg [23:0] addr_reg;
    reg [1:0] abyte_reg;
    reg armed_reg;
    reg data_seen_reg;
    reg [7:0] off_reg;
    reg [7:0] buf_reg [0:PAGE-1];
    reg [PAGE-1:0] mask_reg;
    reg [ADDR_W-1:0] rd_ptr_reg;
    reg [2:0] obit_reg;
    reg [7:0] out_sh_reg;
    reg prog_reg;
    reg [ADDR_W-1:0] walk_reg;
    reg [ADDR_W-1:0] walk_last_reg;
    wire rst_n;
    wire sclk_rise, sclk_fall, cs_rise, cs_fall;
    wire [7:0] in_byte, rd_data, pb_idx, wr_data, out_byte;
    wire [ADDR_W-1:0] rd_addr, tgt_addr;
    wire exec_pp, exec_se, exec_be;
    integer i;

    assign rst_n = rst_s2_reg;
    assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
    assign sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
    assign cs_rise = cs_s2_reg & ~cs_s3_reg;
    assign cs_fall = ~cs_s2_reg & cs_s3_reg;
    assign in_byte = {sh_reg, mosi_s2_reg};
    assign tgt_addr = addr_reg[ADDR_W-1:0];
    assign pb_idx = walk_reg[7:0];
    assign rd_addr = write_in_progress_out ? walk_reg : rd_ptr_reg;
    // Masked bytes AND in, others rewrite their own value
    assign wr_data = prog_reg ? (mask_reg[pb_idx] ? (rd_data & buf_reg[pb_idx]) : rd_data)
                              : `SFR_ERASED;
    assign out_byte = (state_reg == ST_READ) ? rd_data : SIGNATURE;

    // Execute only on exact boundaries, with latch set and no cycle running
    assign exec_pp = (state_reg == ST_PDATA) && (bit_reg == 3'h0) && data_seen_reg
                     && write_enable_latch_out && !write_in_progress_out
                     && !prot_hit(tgt_addr, bp_s2_reg);
    assign exec_se = (state_reg == ST_HOLD) && armed_reg && (cmd_reg == OP_SECTOR_CLEAR)
                     && write_enable_latch_out && !write_in_progress_out
                     && !prot_hit(tgt_addr, bp_s2_reg);
    assign exec_be = (state_reg == ST_HOLD) && armed_reg && (cmd_reg == OP_ARRAY_CLEAR)
                     && write_enable_latch_out && !write_in_progress_out
                     && (bp_s2_reg == 3'h0);

    sfr_array #(
        .ADDR_W(ADDR_W)
    ) u_array (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .wr_en_in(write_in_progress_out),
        .wr_addr_in(walk_reg),
        .wr_data_in(wr_data),
        .rd_addr_in(rd_addr),
        .rd_data_out(rd_data)
    );

    always @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // Pins are asynchronous to mclk; sclk is slow enough to sample
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            mosi_s1_reg <= 1'b0;
            mosi_s2_reg <= 1'b0;
            bp_s1_reg <= 3'h0;
            bp_s2_reg <= 3'h0;
        end
        else
        begin
            sclk_s1_reg <= sclk_in;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            cs_s1_reg <= cs_n_in;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            mosi_s1_reg <= mosi_in;
            mosi_s2_reg <= mosi_s1_reg;
            bp_s1_reg <= block_protect_in;
            bp_s2_reg <= bp_s1_reg;
        end
    end

    // Page buffer; offset wraps in 8 bits so later bytes overwrite earlier
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_reg <= {PAGE{1'b0}};
            for (i = 0; i < PAGE; i = i + 1)
                buf_reg[i] <= 8'h00;
        end
        else if (state_reg == ST_ADDR && sclk_rise && bit_reg == 3'h7
                 && abyte_reg == `SFR_ADDR_BYTES)
        begin
            mask_reg <= {PAGE{1'b0}};
        end
        else if (state_reg == ST_PDATA && sclk_rise && bit_reg == 3'h7 && !cs_s2_reg)
        begin
            buf_reg[off_reg] <= in_byte;
            mask_reg[off_reg] <= 1'b1;
        end
    end

    // Serial front end
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            cmd_reg <= 8'h00;
            bit_reg <= 3'h0;
            sh_reg <= 7'h00;
            addr_reg <= 24'h000000;
            abyte_reg <= 2'h0;
            armed_reg <= 1'b0;
            data_seen_reg <= 1'b0;
            off_reg <= 8'h00;
            rd_ptr_reg <= {ADDR_W{1'b0}};
            obit_reg <= 3'h0;
            out_sh_reg <= 8'h00;
            miso_out <= 1'b0;
            miso_oe_out <= 1'b0;
        end
        else if (cs_s2_reg)
        begin
            // Deselect aborts any instruction at any bit
            state_reg <= ST_IDLE;
            miso_oe_out <= 1'b0;
            armed_reg <= 1'b0;
        end
        else if (cs_fall)
        begin
            state_reg <= ST_CMD;
            bit_reg <= 3'h0;
            abyte_reg <= 2'h0;
            armed_reg <= 1'b0;
            data_seen_reg <= 1'b0;
        end
        else if (sclk_rise && state_reg != ST_IDLE)
        begin
            sh_reg <= in_byte[6:0];
            bit_reg <= bit_reg + 3'h1;
            // A clock past an armed erase breaks its boundary
            if (state_reg == ST_HOLD)
                armed_reg <= 1'b0;
            if (bit_reg == 3'h7)
            begin
                case (state_reg)
                    ST_CMD:
                    begin
                        cmd_reg <= in_byte;
                        state_reg <= ST_HOLD;
                        if (in_byte == OP_FAST_READ && !write_in_progress_out)
                            state_reg <= ST_ADDR;
                        if (in_byte == OP_SIGNATURE)
                            state_reg <= ST_ADDR;
                        if ((in_byte == OP_PAGE_WRITE || in_byte == OP_SECTOR_CLEAR)
                            && write_enable_latch_out && !write_in_progress_out)
                            state_reg <= ST_ADDR;
                        if (in_byte == OP_ARRAY_CLEAR)
                            armed_reg <= 1'b1;
                    end
                    ST_ADDR:
                    begin
                        addr_reg <= {addr_reg[15:0], in_byte};
                        abyte_reg <= abyte_reg + 2'h1;
                        if (abyte_reg == `SFR_ADDR_BYTES)
                        begin
                            off_reg <= in_byte;
                            obit_reg <= 3'h0;
                            if (cmd_reg == OP_FAST_READ)
                                state_reg <= ST_DUMMY;
                            else if (cmd_reg == OP_SIGNATURE)
                                state_reg <= ST_SIG;
                            else if (cmd_reg == OP_PAGE_WRITE)
                                state_reg <= ST_PDATA;
                            else
                            begin
                                state_reg <= ST_HOLD;
                                armed_reg <= 1'b1;
                            end
                        end
                    end
                    ST_DUMMY:
                    begin
                        state_reg <= ST_READ;
                        rd_ptr_reg <= tgt_addr;
                    end
                    ST_PDATA:
                    begin
                        off_reg <= off_reg + 8'h01;
                        data_seen_reg <= 1'b1;
                    end
                    ST_READ, ST_SIG, ST_HOLD: state_reg <= state_reg;
                    default:
                    begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
        else if (sclk_fall && (state_reg == ST_READ || state_reg == ST_SIG))
        begin
            miso_oe_out <= 1'b1;
            obit_reg <= obit_reg + 3'h1;
            if (obit_reg == 3'h0)
            begin
                // Same load path repeats the signature each byte
                miso_out <= out_byte[7];
                out_sh_reg <= {out_byte[6:0], 1'b0};
                if (state_reg == ST_READ)
                    rd_ptr_reg <= rd_ptr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
            end
            else
            begin
                miso_out <= out_sh_reg[7];
                out_sh_reg <= {out_sh_reg[6:0], 1'b0};
            end
        end
    end

    // Self-timed cycle: walks target range one byte per mclk
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            write_in_progress_out <= 1'b0;
            write_enable_latch_out <= 1'b0;
            prog_reg <= 1'b0;
            walk_reg <= {ADDR_W{1'b0}};
            walk_last_reg <= {ADDR_W{1'b0}};
        end
        else if (write_in_progress_out)
        begin
            if (walk_reg == walk_last_reg)
                write_in_progress_out <= 1'b0;
            else
                walk_reg <= walk_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
        end
        else if (cs_rise && (exec_pp || exec_se || exec_be))
        begin
            write_in_progress_out <= 1'b1;
            write_enable_latch_out <= 1'b0;
            prog_reg <= exec_pp;
            if (exec_pp)
            begin
                walk_reg <= {tgt_addr[ADDR_W-1:8], 8'h00};
                walk_last_reg <= {tgt_addr[ADDR_W-1:8], 8'hFF};
            end
            else if (exec_se)
            begin
                walk_reg <= {tgt_addr[ADDR_W-1:SECT_W], {SECT_W{1'b0}}};
                walk_last_reg <= {tgt_addr[ADDR_W-1:SECT_W], {SECT_W{1'b1}}};
            end
            else
            begin
                walk_reg <= {ADDR_W{1'b0}};
                walk_last_reg <= {ADDR_W{1'b1}};
            end
        end
        else if (!cs_s2_reg && state_reg == ST_CMD && sclk_rise && bit_reg == 3'h7
                 && in_byte == OP_WRITE_ENABLE)
        begin
            write_enable_latch_out <= 1'b1;
        end
    end
endmodule // sfr_flash_core

/* File: testbench/sfr_flash_checker.sv */
`timescale 1ns/10ps
module sfr_flash_checker #(
    parameter ADDR_W = 12,
    parameter SECT_W = 10
) (
    input wire mclk_in,
    input wire rstn_in,
    input wire sclk_in,
    input wire cs_n_in,
    input wire mosi_in,
    input wire [2:0] block_protect_in,
    input wire miso_out,
    input wire miso_oe_out,
    input wire write_in_progress_out,
    input wire write_enable_latch_out
);
    localparam int BUSY_MAX = (1 << ADDR_W) + 64;
    reg [12:0] busy_cnt_reg;
    default clocking dck @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);
    // Busy length counter, since cycles run to thousands
    always @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            busy_cnt_reg <= 13'h0000;
        else
            busy_cnt_reg <= write_in_progress_out ? busy_cnt_reg + 13'h0001 : 13'h0000;
    end
    a_rst_idle: assert property ($rose(rstn_in) |-> !write_in_progress_out &&
        !write_enable_latch_out && !miso_oe_out) else $error("flags not idle after reset");
    a_oe_release: assert property (cs_n_in [*6] |-> !miso_oe_out)
        else $error("output driven while deselected");
    a_oe_on_fall: assert property ($rose(miso_oe_out) |-> $past(sclk_in, 2) == 1'b0)
        else $error("output enable not after falling clock");
    a_miso_on_fall: assert property ($changed(miso_out) && miso_oe_out &&
        $past(miso_oe_out) |-> $past(sclk_in, 2) == 1'b0) else $error("data moved off fall");
    a_wip_after_sel: assert property ($rose(write_in_progress_out) |->
        cs_n_in && $past(cs_n_in, 2)) else $error("busy started inside a frame");
    a_wip_needs_wel: assert property ($rose(write_in_progress_out) |->
        $past(write_enable_latch_out)) else $error("cycle started without latch");
    a_wel_cleared: assert property ($rose(write_in_progress_out) |-> ##[0:4]
        !write_enable_latch_out) else $error("latch not cleared in cycle");
    a_busy_min: assert property ($fell(write_in_progress_out) |->
        busy_cnt_reg >= 13'h00FA) else $error("busy cycle too short");
    a_busy_bound: assert property (busy_cnt_reg <= BUSY_MAX)
        else $error("busy cycle never ends");
    a_wel_in_frame: assert property ($rose(write_enable_latch_out) |-> !cs_n_in)
        else $error("latch set outside a frame");
endmodule // sfr_flash_checker

bind sfr_flash_core sfr_flash_checker #(.ADDR_W(ADDR_W), .SECT_W(SECT_W)) sfr_flash_checker_i (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
    .mosi_in(mosi_in), .block_protect_in(block_protect_in), .miso_out(miso_out),
    .miso_oe_out(miso_oe_out), .write_in_progress_out(write_in_progress_out),
    .write_enable_latch_out(write_enable_latch_out));

/* File: testbench/sfr_host_model.sv */
`timescale 1ns/10ps
module sfr_host_model (
    input wire mclk_in,
    input wire miso_in,
    output reg sclk_out,
    output reg cs_n_out,
    output reg mosi_out
);
    integer i;
    initial
    begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    task sel;
    begin
        @(negedge mclk_in);
        cs_n_out = 1'b0;
        repeat (4) @(negedge mclk_in);
    end
    endtask
    // Short n gives a broken byte boundary
    task xb(input [7:0] tx, input integer n, output [7:0] rx);
    begin
        rx = 8'h00;
        for (i = 7; i > 7 - n; i = i - 1)
        begin
            sclk_out = 1'b0;
            mosi_out = tx[i];
            repeat (4) @(negedge mclk_in);
            sclk_out = 1'b1;
            repeat (4) @(negedge mclk_in);
            rx[i] = miso_in;
        end
    end
    endtask
    task desel;
    begin
        sclk_out = 1'b0;
        repeat (4) @(negedge mclk_in);
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        repeat (8) @(negedge mclk_in);
    end
    endtask
endmodule // sfr_host_model

/* File: testbench/tb_sfr_flash_core.sv */
`timescale 1ns/10ps
`include "sfr_regs.vh"
module tb_sfr_flash_core;
    reg mclk_in;
    reg rstn_in;
    reg [2:0] bp;
    wire sclk, cs_n, mosi, miso, oe, write_in_progress, write_enable_latch;
    // Undriven line reads inverted so a stale bit cannot pass a compare
    wire host_miso = oe ? miso : ~miso;
    integer mismatches;
    integer comparisons;
    integer k;
    integer n;
    reg [7:0] d;
    reg [31:0] rows [0:5];
    sfr_flash_core sfr_flash_core_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .sclk_in(sclk),
        .cs_n_in(cs_n), .mosi_in(mosi), .block_protect_in(bp), .miso_out(miso),
        .miso_oe_out(oe), .write_in_progress_out(write_in_progress), .write_enable_latch_out(write_enable_latch));
    sfr_host_model sfr_host_model_i (.mclk_in(mclk_in), .miso_in(host_miso), .sclk_out(sclk),
        .cs_n_out(cs_n), .mosi_out(mosi));
    initial
    begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    task stop_test;
    begin
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task check(input string name, input [7:0] seen, input [7:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    task xs(input [7:0] v);
    begin
        sfr_host_model_i.xb(v, 8, d);
    end
    endtask
    task hdr(input [7:0] op, input [23:0] a);
    begin
        sfr_host_model_i.sel;
        xs(op);
        xs(a[23:16]);
        xs(a[15:8]);
        xs(a[7:0]);
    end
    endtask
    task op1(input [7:0] op, input integer extra);
    begin
        sfr_host_model_i.sel;
        xs(op);
        if (extra > 0)
            sfr_host_model_i.xb(8'h00, extra, d);
        sfr_host_model_i.desel;
    end
    endtask
    task write_enable_cmd;
    begin
        op1(`SFR_OP_WRITE_ENABLE, 0);
        check("wel", {7'h00, write_enable_latch}, 8'h01);
    end
    endtask
    task rd(input [23:0] a);
    begin
        hdr(`SFR_OP_FAST_READ, a);
        xs(8'h00);
        xs(8'hFF);
    end
    endtask
    task busy(input e);
    begin
        check("wip", {7'h00, write_in_progress}, {7'h00, e});
        n = 0;
        while (write_in_progress === 1'b1 && n < 6000)
        begin
            @(negedge mclk_in);
            n = n + 1;
        end
        if (n == 6000)
        begin
            mismatches = mismatches + 1;
            stop_test;
        end
        if (e)
            check("wel", {7'h00, write_enable_latch}, 8'h00);
    end
    endtask
    task pp(input [23:0] a, input [7:0] v, input integer extra, input e);
    begin
        hdr(`SFR_OP_PAGE_WRITE, a);
        xs(v);
        if (extra > 0)
            sfr_host_model_i.xb(8'h00, extra, d);
        sfr_host_model_i.desel;
        busy(e);
    end
    endtask
    initial
    begin
        repeat (90000) @(negedge mclk_in);
        mismatches = mismatches + 1;
        stop_test;
    end
    initial
    begin
        rows[0] = {24'h0000FE, 8'hA0};
        rows[1] = {24'h8000FF, 8'h3C};
        rows[2] = {24'h000000, 8'h0F};
        rows[3] = {24'h000010, 8'hFF};
        rows[4] = {24'h000020, 8'hFF};
        rows[5] = {24'h000030, 8'hFF};
        mismatches = 0;
        comparisons = 0;
        bp = 3'h0;
        rstn_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        rstn_in = 1'b1;
        repeat (6) @(negedge mclk_in);
        check("wel", {7'h00, write_enable_latch}, 8'h00);
        check("wip", {7'h00, write_in_progress}, 8'h00);
        check("oe", {7'h00, oe}, 8'h00);
        write_enable_cmd;
        hdr(`SFR_OP_PAGE_WRITE, 24'h0000FE);
        xs(8'hA5);
        xs(8'h3C);
        xs(8'h0F);
        sfr_host_model_i.desel;
        busy(1'b1);
        pp(24'h000010, 8'h00, 0, 1'b0);
        write_enable_cmd;
        pp(24'h0000FE, 8'hF0, 0, 1'b1);
        write_enable_cmd;
        pp(24'h000020, 8'h00, 4, 1'b0);
        hdr(`SFR_OP_SECTOR_CLEAR, 24'h000000);
        sfr_host_model_i.xb(8'h00, 4, d);
        sfr_host_model_i.desel;
        busy(1'b0);
        bp = 3'h7;
        op1(`SFR_OP_ARRAY_CLEAR, 0);
        busy(1'b0);
        pp(24'h000030, 8'h00, 0, 1'b0);
        bp = 3'h0;
        for (k = 0; k < 6; k = k + 1)
        begin
            rd(rows[k][31:8]);
            sfr_host_model_i.desel;
            check("read", d, rows[k][7:0]);
        end
        rd(24'h000FFF);
        check("top", d, `SFR_ERASED);
        xs(8'hFF);
        check("wrap", d, 8'h0F);
        sfr_host_model_i.desel;
        check("oe", {7'h00, oe}, 8'h00);
        hdr(`SFR_OP_SIGNATURE, 24'h000000);
        xs(8'hFF);
        check("sig", d, `SFR_SIGNATURE);
        xs(8'hFF);
        check("sig2", d, `SFR_SIGNATURE);
        sfr_host_model_i.desel;
        op1(`SFR_OP_SIGNATURE, 3);
        rd(24'h0000FF);
        sfr_host_model_i.desel;
        check("standby", d, 8'h3C);
        write_enable_cmd;
        hdr(`SFR_OP_SECTOR_CLEAR, 24'h8003FF);
        sfr_host_model_i.desel;
        check("wip", {7'h00, write_in_progress}, 8'h01);
        rd(24'h0000FE);
        check("oe", {7'h00, oe}, 8'h00);
        sfr_host_model_i.desel;
        busy(1'b1);
        rd(24'h0000FE);
        sfr_host_model_i.desel;
        check("erase", d, `SFR_ERASED);
        write_enable_cmd;
        hdr(`SFR_OP_PAGE_WRITE, 24'h000100);
        for (k = 0; k < 258; k = k + 1)
            xs((k < 2) ? 8'h11 : 8'h22);
        sfr_host_model_i.desel;
        busy(1'b1);
        rd(24'h000100);
        check("last256", d, 8'h22);
        xs(8'hFF);
        check("last256", d, 8'h22);
        sfr_host_model_i.desel;
        write_enable_cmd;
        op1(`SFR_OP_ARRAY_CLEAR, 4);
        busy(1'b0);
        write_enable_cmd;
        op1(`SFR_OP_ARRAY_CLEAR, 0);
        busy(1'b1);
        rd(24'h000100);
        sfr_host_model_i.desel;
        check("bulk", d, `SFR_ERASED);
        stop_test;
    end
endmodule // tb_sfr_flash_core
